// ---- rtl/mbpu_defines.svh ----
`ifndef MBPU_DEFINES_SVH
`define MBPU_DEFINES_SVH

// ************************************************************
// widths and limits
// ************************************************************
`define MBPU_WORD_W 16
`define MBPU_PTR_W 16
`define MBPU_LEN_W 9
`define MBPU_LEN_MIN 9'h001
`define MBPU_LEN_MAX 9'h100
`define MBPU_MAX_WORDS 256
`define MBPU_ADDR_W 8
`define MBPU_BIT_SEL_W 4
`define MBPU_PTR_ZERO 16'h0000
`define MBPU_PTR_ONE 16'h0001

`endif

// ---- rtl/mbpu_edge_det.sv ----
`timescale 1ns/1ns

// ************************************************************
// rising edge pulse
// ************************************************************
module mbpu_edge_det (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic level_in,
    output logic rise_out
);
    logic level_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_in;
        end
    end

    // held enable gives no repeat execution
    assign rise_out = level_in & ~level_q;
endmodule

// ---- rtl/mbpu_matrix_mem.sv ----
`timescale 1ns/1ns
`include "mbpu_defines.svh"

// ************************************************************
// word store with registered read, bit write port
// ************************************************************
module mbpu_matrix_mem #(
    parameter int DEPTH = `MBPU_MAX_WORDS,
    parameter int AW = `MBPU_ADDR_W
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [`MBPU_WORD_W-1:0] wr_data_in,
    input wire logic bit_wr_en_in,
    input wire logic [AW-1:0] bit_addr_in,
    input wire logic [`MBPU_BIT_SEL_W-1:0] bit_sel_in,
    input wire logic bit_val_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [`MBPU_WORD_W-1:0] rd_data_out
);
    logic [`MBPU_WORD_W-1:0] mem_q [DEPTH];

    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("depth exceeds address space");
        end
    end

    // bit write takes priority over a host word load to any word in the same cycle
    always_ff @(posedge clk_in) begin
        if (bit_wr_en_in) begin
            mem_q[bit_addr_in][bit_sel_in] <= bit_val_in;
        end else if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rd_data_out <= mem_q[rd_addr_in];
    end
endmodule

// ---- rtl/mbpu_pkg.sv ----
package mbpu_pkg;
    typedef enum logic [1:0] {
        MBPU_OP_COMPARE,
        MBPU_OP_READ,
        MBPU_OP_WRITE,
        MBPU_OP_NONE
    } mbpu_op_t;

    typedef enum {
        MBPU_IDLE,
        MBPU_FETCH,
        MBPU_EVAL,
        MBPU_DONE
    } mbpu_state_t;
endpackage

// ---- rtl/mbpu_unit.sv ----
`timescale 1ns/1ns
`include "mbpu_defines.svh"

// Behaviour
// - match flag one on equal, else zero
// - compare stops at equal bit, sets found
// - compare reaching last bit without a match sets end flag
// - compare restarting at bit zero sets start
// - out-of-range pointer sets pointer error
// - after end, next compare restarts at zero
// - length accepted only from 1 to 256
// - read with clear zeroes pointer first
// - read copies addressed bit into carry
// - read increments pointer when increment set
// - read at last bit sets end, holds index
// - write with clear zeroes pointer, writes bit0
// - write increments pointer when increment set
// - write at last bit sets end, holds index
// - read pointer stops at last bit index
module mbpu_unit
    import mbpu_pkg::*;
#(
    parameter int MAX_WORDS = `MBPU_MAX_WORDS
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic EXEC_EN_IN,
    input wire logic [1:0] OP_SEL_IN,
    input wire logic [`MBPU_LEN_W-1:0] MATRIX_LEN_IN,
    input wire logic POINTER_INCREMENT_FLAG_IN,
    input wire logic POINTER_CLEAR_FLAG_IN,
    input wire logic FILL_IN_FLAG_IN,
    input wire logic PTR_LOAD_IN,
    input wire logic [`MBPU_PTR_W-1:0] PTR_LOAD_VAL_IN,
    input wire logic WORD_WR_EN_IN,
    input wire logic WORD_WR_SEL_IN,
    input wire logic [`MBPU_ADDR_W-1:0] WORD_WR_ADDR_IN,
    input wire logic [`MBPU_WORD_W-1:0] WORD_WR_DATA_IN,
    output logic [`MBPU_PTR_W-1:0] POINTER_OUT,
    output logic COMPARE_MATCH_FLAG_OUT,
    output logic SEARCH_END_FLAG_OUT,
    output logic SEARCH_START_FLAG_OUT,
    output logic BIT_FOUND_FLAG_OUT,
    output logic POINTER_ERROR_FLAG_OUT,
    output logic CARRY_OUT_FLAG_OUT,
    output logic BUSY_OUT
);
    initial begin
        if (MAX_WORDS != `MBPU_MAX_WORDS) begin
            $error("matrix depth must be 256 words");
        end
    end

    // ************************************************************
    // trigger and operand checks
    // ************************************************************
    logic exec_rise;
    mbpu_state_t state_q;
    mbpu_op_t op_q;
    logic [`MBPU_PTR_W-1:0] ptr_q;
    logic [`MBPU_PTR_W-1:0] scan_q;
    logic [`MBPU_PTR_W-1:0] last_bit;
    logic len_ok;
    logic restart_q;
    logic cmp_restart;
    logic [`MBPU_WORD_W-1:0] rd_a;
    logic [`MBPU_WORD_W-1:0] rd_b;
    logic [`MBPU_BIT_SEL_W-1:0] bit_sel;
    logic bit_a;
    logic bit_b;
    logic at_last;
    logic wr_bit;

    mbpu_edge_det u_edge (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .level_in(EXEC_EN_IN),
        .rise_out(exec_rise)
    );

    assign len_ok = (MATRIX_LEN_IN >= `MBPU_LEN_MIN)
        && (MATRIX_LEN_IN <= `MBPU_LEN_MAX);
    // bit count 16*n, index of last bit is 16*n-1
    assign last_bit = ({{(`MBPU_PTR_W - `MBPU_LEN_W){1'b0}}, MATRIX_LEN_IN} << `MBPU_BIT_SEL_W)
        - `MBPU_PTR_ONE;
    // restart only from an in-range pointer; out of range is an error instead
    assign cmp_restart = (ptr_q <= last_bit) && (restart_q || ptr_q == last_bit);
    assign bit_sel = scan_q[`MBPU_BIT_SEL_W-1:0];
    assign bit_a = rd_a[bit_sel];
    assign bit_b = rd_b[bit_sel];
    assign at_last = (scan_q == last_bit);
    assign wr_bit = (state_q == MBPU_EVAL) && (op_q == MBPU_OP_WRITE)
        && (scan_q <= last_bit);

    // ************************************************************
    // matrices: source 1 (read and write target) and source 2
    // ************************************************************
    mbpu_matrix_mem u_mem_a (
        .clk_in(REF_CLK_IN),
        .wr_en_in(WORD_WR_EN_IN && !WORD_WR_SEL_IN),
        .wr_addr_in(WORD_WR_ADDR_IN),
        .wr_data_in(WORD_WR_DATA_IN),
        .bit_wr_en_in(wr_bit),
        .bit_addr_in(scan_q[`MBPU_PTR_W-5:`MBPU_BIT_SEL_W]),
        .bit_sel_in(bit_sel),
        .bit_val_in(FILL_IN_FLAG_IN),
        .rd_addr_in(scan_q[`MBPU_PTR_W-5:`MBPU_BIT_SEL_W]),
        .rd_data_out(rd_a)
    );

    mbpu_matrix_mem u_mem_b (
        .clk_in(REF_CLK_IN),
        .wr_en_in(WORD_WR_EN_IN && WORD_WR_SEL_IN),
        .wr_addr_in(WORD_WR_ADDR_IN),
        .wr_data_in(WORD_WR_DATA_IN),
        .bit_wr_en_in(1'b0),
        .bit_addr_in(scan_q[`MBPU_PTR_W-5:`MBPU_BIT_SEL_W]),
        .bit_sel_in(bit_sel),
        .bit_val_in(1'b0),
        .rd_addr_in(scan_q[`MBPU_PTR_W-5:`MBPU_BIT_SEL_W]),
        .rd_data_out(rd_b)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    // a compare walks one bit each two cycles; fetch waits on the read
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            state_q <= MBPU_IDLE;
        end else begin
            case (state_q)
                MBPU_IDLE: begin
                    if (exec_rise && len_ok && OP_SEL_IN != 2'h3) begin
                        state_q <= MBPU_FETCH;
                    end
                end
                MBPU_FETCH: begin
                    state_q <= (scan_q > last_bit) ? MBPU_DONE : MBPU_EVAL;
                end
                MBPU_EVAL: begin
                    if (op_q == MBPU_OP_COMPARE && bit_a != bit_b && !at_last) begin
                        state_q <= MBPU_FETCH;
                    end else begin
                        state_q <= MBPU_DONE;
                    end
                end
                MBPU_DONE: begin
                    state_q <= MBPU_IDLE;
                end
                default: begin
                    state_q <= MBPU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            op_q <= MBPU_OP_NONE;
        end else if (state_q == MBPU_IDLE && exec_rise) begin
            op_q <= mbpu_op_t'(OP_SEL_IN);
        end
    end

    // ************************************************************
    // scan position and pointer
    // ************************************************************
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            scan_q <= `MBPU_PTR_ZERO;
        end else if (state_q == MBPU_IDLE && exec_rise) begin
            if (OP_SEL_IN == 2'h0) begin
                // compare resumes after the last found bit
                if (ptr_q > last_bit) begin
                    scan_q <= ptr_q;
                end else begin
                    scan_q <= cmp_restart
                        ? `MBPU_PTR_ZERO : ptr_q + `MBPU_PTR_ONE;
                end
            end else begin
                scan_q <= POINTER_CLEAR_FLAG_IN ? `MBPU_PTR_ZERO : ptr_q;
            end
        end else if (state_q == MBPU_EVAL && op_q == MBPU_OP_COMPARE) begin
            scan_q <= scan_q + `MBPU_PTR_ONE;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            ptr_q <= `MBPU_PTR_ZERO;
        end else if (PTR_LOAD_IN && state_q == MBPU_IDLE) begin
            ptr_q <= PTR_LOAD_VAL_IN;
        end else if (state_q == MBPU_EVAL) begin
            if (op_q == MBPU_OP_COMPARE) begin
                ptr_q <= scan_q;
            end else if (POINTER_INCREMENT_FLAG_IN && !at_last) begin
                ptr_q <= scan_q + `MBPU_PTR_ONE;
            end else begin
                ptr_q <= scan_q;
            end
        end else if (state_q == MBPU_FETCH && scan_q > last_bit) begin
            ptr_q <= scan_q;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            restart_q <= 1'b1;
        end else if (PTR_LOAD_IN && state_q == MBPU_IDLE) begin
            // the next search resumes at the bit just after a loaded pointer below the last bit; at the last bit it restarts at zero
            restart_q <= 1'b0;
        end else if (state_q == MBPU_EVAL && op_q == MBPU_OP_COMPARE) begin
            restart_q <= (bit_a != bit_b) && at_last;
        end
    end

    // ************************************************************
    // flags
    // ************************************************************
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            COMPARE_MATCH_FLAG_OUT <= 1'b0;
            BIT_FOUND_FLAG_OUT <= 1'b0;
        end else if (state_q == MBPU_EVAL && op_q == MBPU_OP_COMPARE) begin
            COMPARE_MATCH_FLAG_OUT <= (bit_a == bit_b);
            BIT_FOUND_FLAG_OUT <= (bit_a == bit_b);
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            SEARCH_START_FLAG_OUT <= 1'b0;
        end else if (state_q == MBPU_IDLE && exec_rise && OP_SEL_IN == 2'h0 && len_ok) begin
            SEARCH_START_FLAG_OUT <= cmp_restart;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            SEARCH_END_FLAG_OUT <= 1'b0;
        end else if (state_q == MBPU_EVAL) begin
            if (op_q == MBPU_OP_COMPARE) begin
                SEARCH_END_FLAG_OUT <= at_last && (bit_a != bit_b);
            end else begin
                // end once the last bit itself has been read or written
                SEARCH_END_FLAG_OUT <= at_last;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            POINTER_ERROR_FLAG_OUT <= 1'b0;
        end else if (state_q == MBPU_FETCH) begin
            POINTER_ERROR_FLAG_OUT <= (scan_q > last_bit);
        end else if (state_q == MBPU_IDLE && exec_rise && !len_ok) begin
            POINTER_ERROR_FLAG_OUT <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            CARRY_OUT_FLAG_OUT <= 1'b0;
        end else if (state_q == MBPU_EVAL && op_q == MBPU_OP_READ) begin
            CARRY_OUT_FLAG_OUT <= bit_a;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            POINTER_OUT <= `MBPU_PTR_ZERO;
            BUSY_OUT <= 1'b0;
        end else begin
            POINTER_OUT <= ptr_q;
            BUSY_OUT <= (state_q != MBPU_IDLE);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    one_per_edge_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_IDLE && !exec_rise) |=> state_q == MBPU_IDLE)
        else $error("execution started without idle edge");
    carry_copy_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_EVAL && op_q == MBPU_OP_READ) |=> (CARRY_OUT_FLAG_OUT == $past(bit_a)))
        else $error("carry not the read bit");
    match_found_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_EVAL && op_q == MBPU_OP_COMPARE && bit_a == bit_b)
        |=> COMPARE_MATCH_FLAG_OUT && BIT_FOUND_FLAG_OUT && state_q == MBPU_DONE)
        else $error("match not flagged");
    stop_at_match_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_EVAL && op_q == MBPU_OP_COMPARE && bit_a == bit_b)
        |=> ptr_q == $past(scan_q))
        else $error("pointer not at match");
    clear_ptr_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_IDLE && exec_rise && OP_SEL_IN != 2'h0 && POINTER_CLEAR_FLAG_IN)
        |=> scan_q == `MBPU_PTR_ZERO)
        else $error("clear flag ignored");
    step_inc_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_EVAL && op_q != MBPU_OP_COMPARE && POINTER_INCREMENT_FLAG_IN && !at_last)
        |=> ptr_q == $past(scan_q) + `MBPU_PTR_ONE)
        else $error("pointer not incremented");
    last_hold_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_EVAL && op_q != MBPU_OP_COMPARE && at_last) |=> ptr_q == $past(last_bit))
        else $error("pointer passed last bit");
    read_end_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_EVAL && op_q != MBPU_OP_COMPARE && at_last) |=> SEARCH_END_FLAG_OUT)
        else $error("end flag missed at last bit");
    ptr_error_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_FETCH && scan_q > last_bit) |=> POINTER_ERROR_FLAG_OUT ##2 !BUSY_OUT)
        else $error("pointer error missed");
    bad_len_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_q == MBPU_IDLE && exec_rise && !len_ok) |=> state_q == MBPU_IDLE)
        else $error("bad length executed");
    cmp_run_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        state_q == MBPU_EVAL && op_q == MBPU_OP_COMPARE && bit_a == bit_b);
    cmp_end_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        $rose(SEARCH_END_FLAG_OUT) && op_q == MBPU_OP_COMPARE);
    rd_end_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        $rose(SEARCH_END_FLAG_OUT) && op_q == MBPU_OP_READ);
    wr_bit_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN) wr_bit);
endmodule

// ---- verification/matrix_bit_pointer_unit_bench.sv ----
`timescale 1ns/1ns
module matrix_bit_pointer_unit_bench;
    import mbpu_pkg::*;
    typedef struct {
        logic [15:0] ptr;
        logic [5:0] fl;
        logic [5:0] msk;
    } mbpu_note_t;
    // ************************************************************
    // stimulus signals and bookkeeping
    // ************************************************************
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, inc = 1'b0, clr = 1'b0, fill = 1'b0;
    logic pld = 1'b0, wen = 1'b0, wsel = 1'b0, chk = 1'b0;
    logic [1:0] op = 2'h3;
    logic [8:0] len = 9'h003;
    logic [15:0] pval = 16'h0000, wdata = 16'h0000;
    logic [7:0] waddr = 8'h00;
    logic [15:0] ptr_out;
    logic match, s_end, s_start, found, err, carry, busy;
    logic [15:0] a_w [256];
    logic [15:0] wd;
    logic fb;
    logic [5:0] flv;
    mbpu_note_t notes[$];
    mbpu_note_t nt;
    string fname [6] = '{"carry", "error", "found", "start", "end", "match"};
    int num_errors = 0, n_checks = 0, seed = 82609, cyc = 0, k, j;
    int cp [4] = '{5, 9, 15, 5};
    always #10 clk = ~clk;
    assign flv = {match, s_end, s_start, found, err, carry};
    mbpu_unit dut (
        .REF_CLK_IN(clk), .RST_IN(rst), .EXEC_EN_IN(en), .OP_SEL_IN(op),
        .MATRIX_LEN_IN(len), .POINTER_INCREMENT_FLAG_IN(inc),
        .POINTER_CLEAR_FLAG_IN(clr), .FILL_IN_FLAG_IN(fill), .PTR_LOAD_IN(pld),
        .PTR_LOAD_VAL_IN(pval), .WORD_WR_EN_IN(wen), .WORD_WR_SEL_IN(wsel),
        .WORD_WR_ADDR_IN(waddr), .WORD_WR_DATA_IN(wdata), .POINTER_OUT(ptr_out),
        .COMPARE_MATCH_FLAG_OUT(match), .SEARCH_END_FLAG_OUT(s_end),
        .SEARCH_START_FLAG_OUT(s_start), .BIT_FOUND_FLAG_OUT(found),
        .POINTER_ERROR_FLAG_OUT(err), .CARRY_OUT_FLAG_OUT(carry), .BUSY_OUT(busy)
    );
    // ************************************************************
    // compare and report
    // ************************************************************
    task automatic cmp_ptr(input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected pointer: expected %h seen %h", e, g);
        end
    endtask
    task automatic cmp_flag(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s flag: expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // a result appears once the driver has seen the execution settle
    always @(posedge clk) begin
        if (chk === 1'b1) begin
            nt = notes.pop_front();
            cmp_ptr(nt.ptr, ptr_out);
            for (j = 0; j < 6; j++) begin
                if (nt.msk[j]) begin
                    cmp_flag(fname[j], nt.fl[j], flv[j]);
                end
            end
        end
    end
    // hang guard, the longest run is well under this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("unexpected timeout: expected done seen busy");
            summarize();
        end
    end
    // ************************************************************
    // drivers
    // ************************************************************
    task automatic wr(input logic s, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #2 wen = 1'b1; wsel = s; waddr = a; wdata = d;
        @(posedge clk);
        #2 wen = 1'b0;
    endtask
    task automatic ld(input logic [15:0] v);
        @(posedge clk);
        #2 pld = 1'b1; pval = v;
        @(posedge clk);
        #2 pld = 1'b0;
    endtask
    task automatic note(input logic [15:0] p, input logic [5:0] f, input logic [5:0] m);
        notes.push_back('{p, f, m});
    endtask
    task automatic exec(input logic [1:0] o, input logic [8:0] l, input logic c, i, f, d);
        int w;
        @(posedge clk);
        #2 op = o; len = l; clr = c; inc = i; fill = f; en = 1'b1;
        // a second rise while busy must be swallowed
        if (d) begin
            @(posedge clk);
            #2 en = 1'b0;
            @(posedge clk);
            #2 en = 1'b1;
        end
        w = 0;
        while (busy !== 1'b1 && w < 8) begin @(posedge clk); #1; w++; end
        w = 0;
        while (busy !== 1'b0 && w < 2000) begin @(posedge clk); #1; w++; end
        if (w >= 2000) begin
            num_errors++;
            $display("unexpected busy: expected 0 seen 1");
        end
        #1 en = 1'b0;
        repeat (3) @(posedge clk);
        #2 chk = 1'b1;
        @(posedge clk);
        #2 chk = 1'b0;
    endtask
    task automatic rd3(input logic d);
        ld(16'd45);
        for (k = 0; k < 3; k++) begin
            note((k == 2) ? 16'd47 : 16'(46 + k), {1'b0, k == 2, 3'b000, a_w[2][13+k]}, 6'b010011);
            exec(2'h1, 9'h003, 1'b0, 1'b1, 1'b0, d && k == 0);
        end
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (16) @(posedge clk);
        #2 rst = 1'b0;
        for (k = 0; k < 3; k++) begin
            a_w[k] = $random(seed);
            if (k == 2) a_w[k] = (a_w[k] & 16'h1fff) | 16'hc000;
            wr(1'b0, 8'(k), a_w[k]);
            wr(1'b1, 8'(k), $random(seed));
        end
        ld(16'd7);
        note(16'd1, {5'b00000, a_w[0][0]}, 6'b010011);
        exec(2'h1, 9'h003, 1'b1, 1'b1, 1'b0, 1'b0);
        ld(16'd20);
        note(16'd20, {5'b00000, a_w[1][4]}, 6'b010011);
        exec(2'h1, 9'h003, 1'b0, 1'b0, 1'b0, 1'b0);
        rd3(1'b1);
        $display("test read done");
        ld(16'd45);
        for (k = 0; k < 3; k++) begin
            note((k == 2) ? 16'd47 : 16'(46 + k), {1'b0, k == 2, 4'h0}, 6'b010010);
            exec(2'h2, 9'h003, 1'b0, 1'b1, k != 1, 1'b0);
            a_w[2][13+k] = (k != 1);
        end
        rd3(1'b0);
        fb = ~a_w[0][0];
        ld(16'd9);
        note(16'd0, 6'h00, 6'b010010);
        exec(2'h2, 9'h003, 1'b1, 1'b0, fb, 1'b0);
        note(16'd0, {5'b00000, fb}, 6'b010011);
        exec(2'h1, 9'h003, 1'b1, 1'b0, 1'b0, 1'b0);
        $display("test write done");
        ld(16'd48);
        note(16'd48, 6'h02, 6'b000010);
        exec(2'h1, 9'h003, 1'b0, 1'b1, 1'b0, 1'b0);
        ld(16'hffff);
        note(16'hffff, 6'h02, 6'b000010);
        exec(2'h2, 9'h003, 1'b0, 1'b1, 1'b1, 1'b0);
        note(16'hffff, 6'h02, 6'b000010);
        exec(2'h1, 9'h000, 1'b0, 1'b1, 1'b0, 1'b0);
        note(16'hffff, 6'h02, 6'b000010);
        exec(2'h1, 9'h101, 1'b0, 1'b1, 1'b0, 1'b0);
        // no operation selected: clear flag must not touch the pointer
        note(16'hffff, 6'h02, 6'b000010);
        exec(2'h3, 9'h003, 1'b1, 1'b1, 1'b0, 1'b0);
        wd = $random(seed);
        wr(1'b0, 8'hff, wd);
        ld(16'd4095);
        note(16'd4095, {5'b01000, wd[15]}, 6'b010011);
        exec(2'h1, 9'h100, 1'b0, 1'b1, 1'b0, 1'b0);
        ld(16'd4096);
        note(16'd4096, 6'h02, 6'b000010);
        exec(2'h1, 9'h100, 1'b0, 1'b1, 1'b0, 1'b0);
        $display("test range done");
        // only bits 5 and 9 agree between the two words
        wr(1'b0, 8'h00, 16'h0000);
        wr(1'b1, 8'h00, 16'hfddf);
        ld(16'd2);
        for (k = 0; k < 4; k++) begin
            note(16'(cp[k]), {k != 2, k == 2, k == 3, k != 2, 2'b00}, (k == 2) ? 6'b110110 : 6'b111110);
            exec(2'h0, 9'h001, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        ld(16'd16);
        note(16'd16, 6'h02, 6'b000010);
        exec(2'h0, 9'h001, 1'b0, 1'b0, 1'b0, 1'b0);
        $display("test compare done");
        repeat (2) @(posedge clk);
        summarize();
    end
endmodule
